/* rtl/dps_pkg.sv */
// Contract
// - Action from CKE history, state, command.
// - Controller waits mode-register timings before CKE low.
// - Power-down entry/exit only with deselect or NOP.
// - Self-refresh exit only with deselect or NOP.
// - Entry while busy: precharge if banks closed.
// - Idle or refreshing entry gives precharge power-down.
// - Refresh with CKE falling enters self-refresh from idle.
// - No self-refresh request during read or write.
// - No internal refresh during power-down.
// - CKE low holds state, commands ignored.
// - Controller holds CKE for minimum pulse time.
// - Only deselect or NOP during self-refresh exit delay.
// - No read or termination before DLL exit delay; controller still passes termination on the exit request itself.
// - No write before 512 cycles after exit.
// - Termination ignored; unavailable in self-refresh.
// - Controller avoids unlisted state and CKE combinations.
// - Other states use only legal commands.
package dps_pkg;
  localparam int CK_DIV = 6;
  localparam int CKE_MIN_CK = 3;
  localparam int MOD_CK = 12;
  localparam int XS_CK = 16;
  localparam int XSDLL_CK = 512;
  localparam int WR_AFTER_SRX_CK = 512;
  localparam int BURST_CK = 4;
  localparam int NBANK = 8;
  localparam logic [31:0] CKE_RESET = 32'h0;
  // Command encoding {CS#, RAS#, CAS#, WE#}.
  localparam logic [3:0] CMD_DES = 4'h8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  typedef enum logic [6:0] {
    DPS_IDLE = 7'h01,
    DPS_ACTIVE = 7'h02,
    DPS_BUSY = 7'h04,
    DPS_REFRESHING = 7'h08,
    DPS_PPD = 7'h10,
    DPS_APD = 7'h20,
    DPS_SREF = 7'h40
  } dps_state_e;
  function automatic logic dps_is_quiet(input logic [3:0] cmd);
    return cmd[3] || (cmd == CMD_NOP);
  endfunction
endpackage

/* rtl/dps_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dps_link_if;
  logic ck;
  logic cke;
  logic [3:0] cmd;
  logic [2:0] ba;
  logic a10;
  logic odt;
  modport dev (input ck, input cke, input cmd, input ba, input a10,
    input odt);
  modport ctl (output ck, output cke, output cmd, output ba, output a10,
    output odt);
endinterface
`default_nettype wire

/* rtl/dps_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Brings a pin into the clock domain and flags its rising edge.
module dps_edge_sync (
  input wire logic SYS_CLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic pin, // Raw pin level.
  output logic level, // Synchronised level.
  output logic rise // One-cycle pulse on a rising edge.
);
  logic meta;
  logic prev;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end
  assign rise = level & ~prev;
endmodule
`default_nettype wire

/* rtl/dps_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Memory-side power-state tracker, evaluated on each link clock rise.
module dps_device
  import dps_pkg::*;
(
  input wire logic SYS_CLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  dps_link_if.dev LINK, // Link from the controller.
  output var dps_pkg::dps_state_e STATE, // Current power state.
  output logic ILLEGAL, // Pulse on an unlisted combination.
  output logic SELF_REFRESH, // High while in self-refresh.
  output logic ODT_ACTIVE // Termination enable seen by the core.
);
  import dps_pkg::*;
  logic ck_rise;
  logic cke_s0;
  logic cke_s1;
  logic odt_s0;
  logic odt_s1;
  logic [3:0] cmd_s0;
  logic [3:0] cmd_s1;
  logic [2:0] ba_s0;
  logic [2:0] ba_s1;
  logic a10_s0;
  logic a10_s1;
  logic cke_prev;
  logic awake;
  logic cke_steady;
  logic [NBANK-1:0] open_bank;
  logic [2:0] busy_cnt;
  dps_state_e next_state;
  logic next_illegal;

  // Reads, writes and precharges keep the array busy for a while.
  function automatic logic is_timed_op(input logic [3:0] cmd);
    return cmd == CMD_RD || cmd == CMD_WR || cmd == CMD_PRE;
  endfunction

  // Leaving power-down or a busy state lands by the open banks.
  function automatic dps_state_e wake_state(input logic [NBANK-1:0] b);
    return (|b) ? DPS_ACTIVE : DPS_IDLE;
  endfunction

  dps_edge_sync u_ck (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .pin(LINK.ck),
    .level(),
    .rise(ck_rise)
  );

  // Every link pin passes two flip-flops, as the link clock does.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cke_s0 <= 1'b0;
      cke_s1 <= 1'b0;
      odt_s0 <= 1'b0;
      odt_s1 <= 1'b0;
      cmd_s0 <= CMD_DES;
      cmd_s1 <= CMD_DES;
      ba_s0 <= 3'h0;
      ba_s1 <= 3'h0;
      a10_s0 <= 1'b0;
      a10_s1 <= 1'b0;
    end else begin
      cke_s0 <= LINK.cke;
      cke_s1 <= cke_s0;
      odt_s0 <= LINK.odt;
      odt_s1 <= odt_s0;
      cmd_s0 <= LINK.cmd;
      cmd_s1 <= cmd_s0;
      ba_s0 <= LINK.ba;
      ba_s1 <= ba_s0;
      a10_s0 <= LINK.a10;
      a10_s1 <= a10_s0;
    end
  end

  // CKE at the previous link edge.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cke_prev <= 1'b0;
    end else if (ck_rise) begin
      cke_prev <= cke_s1;
    end
  end

  // CKE stays low from reset until the controller first raises it; that
  // stretch is neither power-down nor an unlisted combination.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      awake <= 1'b0;
    end else if (ck_rise && cke_s1) begin
      awake <= 1'b1;
    end
  end
  assign cke_steady = cke_prev && cke_s1;

  always_comb begin
    next_state = STATE;
    next_illegal = 1'b0;
    unique case (STATE)
      DPS_PPD, DPS_APD: begin
        if (cke_s1) begin
          if (dps_is_quiet(cmd_s1)) begin
            next_state = wake_state(open_bank);
          end else begin
            next_illegal = 1'b1;
          end
        end else begin
          // Low CKE holds power-down, ignores commands, refreshes nothing.
          next_state = STATE;
        end
      end
      DPS_SREF: begin
        if (cke_s1) begin
          if (dps_is_quiet(cmd_s1)) begin
            next_state = DPS_IDLE;
          end else begin
            next_illegal = 1'b1;
          end
        end else begin
          next_state = STATE;
        end
      end
      default: begin
        if (cke_prev && !cke_s1) begin
          if (dps_is_quiet(cmd_s1)) begin
            if (STATE == DPS_IDLE || STATE == DPS_REFRESHING) begin
              next_state = DPS_PPD;
            end else if (STATE == DPS_BUSY) begin
              next_state = (|open_bank) ? DPS_APD : DPS_PPD;
            end else begin
              next_state = DPS_APD;
            end
          end else if (cmd_s1 == CMD_REF && STATE == DPS_IDLE) begin
            next_state = DPS_SREF;
          end else begin
            next_illegal = 1'b1;
          end
        end else if (!cke_s1) begin
          // Low-low outside power-down is unlisted once CKE has been high.
          next_illegal = awake;
        end else if (cmd_s1 == CMD_REF && STATE == DPS_IDLE) begin
          next_state = DPS_REFRESHING;
        end else if (is_timed_op(cmd_s1)) begin
          next_state = DPS_BUSY;
        end else if (busy_cnt == 3'h0 && STATE != DPS_IDLE &&
                     dps_is_quiet(cmd_s1)) begin
          next_state = wake_state(open_bank);
        end else if (cmd_s1 == CMD_ACT) begin
          next_state = DPS_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      STATE <= DPS_IDLE;
    end else if (ck_rise) begin
      STATE <= next_state;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ILLEGAL <= 1'b0;
    end else begin
      ILLEGAL <= ck_rise && next_illegal;
    end
  end

  // Bank open tracking, only on edges with CKE high at both ends.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      open_bank <= '0;
    end else if (ck_rise && cke_steady) begin
      if (cmd_s1 == CMD_ACT) begin
        open_bank[ba_s1] <= 1'b1;
      end else if (cmd_s1 == CMD_PRE && a10_s1) begin
        open_bank <= '0;
      end else if (cmd_s1 == CMD_PRE) begin
        open_bank[ba_s1] <= 1'b0;
      end
    end
  end

  // Operation length in link cycles.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_cnt <= 3'h0;
    end else if (ck_rise && cke_steady) begin
      if (is_timed_op(cmd_s1) || cmd_s1 == CMD_REF) begin
        busy_cnt <= 3'(BURST_CK);
      end else if (busy_cnt != 3'h0) begin
        busy_cnt <= busy_cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SELF_REFRESH <= 1'b0;
    end else begin
      SELF_REFRESH <= (STATE == DPS_SREF);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ODT_ACTIVE <= 1'b0;
    end else begin
      ODT_ACTIVE <= odt_s1 && (STATE != DPS_SREF);
    end
  end
endmodule
`default_nettype wire

/* rtl/dps_controller.sv */
`timescale 1ns/1ps
`default_nettype none
// Controller end: makes CK by division and sequences CKE and commands.
module dps_controller
  import dps_pkg::*;
(
  input wire logic SYS_CLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  dps_link_if.ctl LINK, // Link to the memory.
  input wire logic REQ_VALID, // Request strobe, held until taken.
  input wire logic [3:0] REQ_CMD, // Requested command.
  input wire logic [2:0] REQ_BA, // Bank address.
  input wire logic REQ_A10, // All-bank select.
  input wire logic REQ_CKE, // Requested CKE level.
  input wire logic REQ_ODT, // Requested termination.
  output logic REQ_TAKEN, // Pulse when request is launched.
  output logic [NBANK-1:0] BANKS_OPEN // Tracked open banks.
);
  import dps_pkg::*;
  logic [2:0] div;
  logic [9:0] mod_cnt, cke_cnt, xs_cnt, dll_cnt, wr_cnt, rw_cnt;
  logic in_sref;
  logic edge_now, allowed;
  always_comb begin
    edge_now = (div == 3'(CK_DIV - 1)) && !LINK.ck;
    allowed = 1'b1;
    if (REQ_CKE != LINK.cke && cke_cnt != 10'h0) allowed = 1'b0;
    if (!REQ_CKE && LINK.cke && mod_cnt != 10'h0) allowed = 1'b0;
    if (REQ_CKE != LINK.cke && !dps_is_quiet(REQ_CMD) &&
        !(REQ_CMD == CMD_REF && !REQ_CKE && BANKS_OPEN == '0))
      allowed = 1'b0;
    if (xs_cnt != 10'h0 && !dps_is_quiet(REQ_CMD))
      allowed = 1'b0;
    if (dll_cnt != 10'h0 && (REQ_CMD == CMD_RD || REQ_ODT))
      allowed = 1'b0;
    if (wr_cnt != 10'h0 && REQ_CMD == CMD_WR) allowed = 1'b0;
    if (rw_cnt != 10'h0 && REQ_CMD == CMD_REF && !REQ_CKE)
      allowed = 1'b0;
    if (!LINK.cke && !REQ_CKE && !dps_is_quiet(REQ_CMD))
      allowed = 1'b0;
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div <= 3'h0;
      LINK.ck <= 1'b0;
    end else if (div == 3'(CK_DIV - 1)) begin
      div <= 3'h0;
      LINK.ck <= ~LINK.ck;
    end else div <= div + 3'h1;
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.cke <= CKE_RESET[0];
      LINK.cmd <= CMD_DES;
      LINK.ba <= 3'h0;
      LINK.a10 <= 1'b0;
      LINK.odt <= 1'b0;
      REQ_TAKEN <= 1'b0;
    end else begin
      REQ_TAKEN <= 1'b0;
      if (edge_now) begin
        if (REQ_VALID && allowed) begin
          LINK.cke <= REQ_CKE;
          LINK.cmd <= REQ_CMD;
          LINK.ba <= REQ_BA;
          LINK.a10 <= REQ_A10;
          LINK.odt <= REQ_ODT && !(in_sref && !REQ_CKE);
          REQ_TAKEN <= 1'b1;
        end else begin
          LINK.cmd <= CMD_DES;
        end
      end
    end
  end
  // Timers in link cycles and bank bookkeeping.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mod_cnt <= 10'h0;
      cke_cnt <= 10'h0;
      xs_cnt <= 10'h0;
      dll_cnt <= 10'h0;
      wr_cnt <= 10'h0;
      rw_cnt <= 10'h0;
      in_sref <= 1'b0;
      BANKS_OPEN <= '0;
    end else if (edge_now) begin
      if (mod_cnt != 10'h0) mod_cnt <= mod_cnt - 10'h1;
      if (cke_cnt != 10'h0) cke_cnt <= cke_cnt - 10'h1;
      if (xs_cnt != 10'h0) xs_cnt <= xs_cnt - 10'h1;
      if (dll_cnt != 10'h0) dll_cnt <= dll_cnt - 10'h1;
      if (wr_cnt != 10'h0) wr_cnt <= wr_cnt - 10'h1;
      if (rw_cnt != 10'h0) rw_cnt <= rw_cnt - 10'h1;
      if (REQ_VALID && allowed) begin
        if (REQ_CMD == CMD_MRS) mod_cnt <= 10'(MOD_CK);
        if (REQ_CMD == CMD_RD || REQ_CMD == CMD_WR) rw_cnt <= 10'(BURST_CK);
        if (REQ_CKE != LINK.cke) cke_cnt <= 10'(CKE_MIN_CK - 1);
        if (!REQ_CKE && LINK.cke && REQ_CMD == CMD_REF) in_sref <= 1'b1;
        if (REQ_CKE && !LINK.cke && in_sref) begin
          in_sref <= 1'b0;
          xs_cnt <= 10'(XS_CK);
          dll_cnt <= 10'(XSDLL_CK);
          wr_cnt <= 10'(WR_AFTER_SRX_CK);
        end
        if (REQ_CKE && LINK.cke) begin
          if (REQ_CMD == CMD_ACT) BANKS_OPEN[REQ_BA] <= 1'b1;
          if (REQ_CMD == CMD_PRE) begin
            if (REQ_A10) BANKS_OPEN <= '0;
            else BANKS_OPEN[REQ_BA] <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verif/dps_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module dps_link_properties
  import dps_pkg::*;
(
  input wire logic SYS_CLK, // System clock.
  input wire logic RST_N, // Reset, active low.
  input wire logic ck, // Link clock.
  input wire logic cke, // Clock enable.
  input wire logic [3:0] cmd, // Command code.
  input wire logic odt // Termination request.
);
  logic ck_q;
  logic cke_q;
  logic in_sr;
  logic rise;
  logic quiet;
  int n_cke;
  int n_srx;
  int n_mrs;
  int n_rw;
  function automatic int sat(input int n);
    return (n < 999) ? n + 1 : n;
  endfunction
  assign rise = ck && !ck_q;
  assign quiet = cmd[3] || cmd == CMD_NOP;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ck_q <= 1'b0;
      cke_q <= 1'b0;
    end else begin
      ck_q <= ck;
      cke_q <= cke;
    end
  end
  // Counters hold link cycles since the last event, each taken at a rise.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      n_cke <= 999;
      n_srx <= 999;
      n_mrs <= 999;
      n_rw <= 999;
      in_sr <= 1'b0;
    end else if (rise) begin
      n_cke <= (cke != cke_q) ? 1 : sat(n_cke);
      n_srx <= (in_sr && cke) ? 1 : sat(n_srx);
      n_mrs <= (cmd == CMD_MRS) ? 1 : sat(n_mrs);
      n_rw <= (cmd == CMD_RD || cmd == CMD_WR) ? 1 : sat(n_rw);
      in_sr <= in_sr ? !cke : (cke_q && !cke && cmd == CMD_REF);
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_ck_high_span: assert property (
    $rose(ck) |-> ck [*6] ##1 !ck)
    else $error("Link clock high phase has the wrong length.");
  a_ck_low_span: assert property (
    $fell(ck) |-> !ck [*6] ##1 ck)
    else $error("Link clock low phase has the wrong length.");
  a_cke_at_rise: assert property (
    $changed(cke) |-> rise)
    else $error("Clock enable moved away from a link rise.");
  a_cke_quiet: assert property (
    rise && cke != cke_q |-> quiet || (!cke && cmd == CMD_REF))
    else $error("Clock enable moved with a busy command.");
  a_cke_hold: assert property (
    rise && cke != cke_q |-> n_cke >= CKE_MIN_CK - 1)
    else $error("Clock enable moved before its hold time.");
  a_mrs_gap: assert property (
    rise && cke_q && !cke |-> n_mrs >= MOD_CK)
    else $error("Clock enable fell too soon after a mode set.");
  a_srx_quiet: assert property (
    rise && n_srx < XS_CK |-> quiet)
    else $error("Command too soon after self-refresh exit.");
  a_srx_read: assert property (
    rise && n_srx < XSDLL_CK |-> cmd != CMD_RD && !odt)
    else $error("Read or termination too soon after exit.");
  a_srx_write: assert property (
    rise && n_srx < WR_AFTER_SRX_CK |-> cmd != CMD_WR)
    else $error("Write too soon after self-refresh exit.");
  a_sre_burst: assert property (
    rise && cke_q && !cke && cmd == CMD_REF |-> n_rw >= BURST_CK)
    else $error("Self-refresh entry during a burst.");
  c_sre: cover property (rise && cke_q && !cke && cmd == CMD_REF);
  c_srx: cover property (rise && in_sr && cke);
  c_pde: cover property (rise && cke_q && !cke && quiet);
endmodule
`default_nettype wire

/* verif/test_ddr3_cke_power_state_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ddr3_cke_power_state_control;
  import dps_pkg::*;
  logic SYS_CLK;
  logic RST_N;
  logic req_valid;
  logic [3:0] req_cmd;
  logic [2:0] req_ba;
  logic req_a10;
  logic req_cke;
  logic req_odt;
  logic req_taken;
  logic [NBANK-1:0] banks_open;
  dps_state_e state;
  dps_state_e state2;
  logic ill;
  logic ill2;
  logic sref;
  logic odt_on;
  logic odt_on2;
  logic seen_ill;
  logic seen_ill2;
  int mismatches;
  int checked;
  int cyc;
  int t0;
  int t_taken;
  dps_link_if link();
  dps_link_if link2();
  dps_controller dps_controller_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .LINK(link.ctl), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
    .REQ_BA(req_ba), .REQ_A10(req_a10), .REQ_CKE(req_cke),
    .REQ_ODT(req_odt), .REQ_TAKEN(req_taken), .BANKS_OPEN(banks_open));
  dps_device dps_device_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .LINK(link.dev), .STATE(state), .ILLEGAL(ill), .SELF_REFRESH(sref),
    .ODT_ACTIVE(odt_on));
  // Second device, driven by the bench so that it sees broken sequences.
  dps_device dps_device_inst2 (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .LINK(link2.dev), .STATE(state2), .ILLEGAL(ill2), .SELF_REFRESH(),
    .ODT_ACTIVE(odt_on2));
  dps_link_properties dps_link_properties_inst (.SYS_CLK(SYS_CLK),
    .RST_N(RST_N), .ck(link.ck), .cke(link.cke), .cmd(link.cmd),
    .odt(link.odt));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (ill) seen_ill <= 1'b1;
    if (ill2) seen_ill2 <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic [2:0] b,
      input logic a, input logic k, input logic o);
    int n;
    req_cmd = c;
    req_ba = b;
    req_a10 = a;
    req_cke = k;
    req_odt = o;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(negedge SYS_CLK);
      n++;
    end while (req_taken !== 1'b1 && n < 8000);
    if (req_taken !== 1'b1) chk(1'b0, 1'b1);
    t_taken = cyc;
    req_valid = 1'b0;
    repeat (6) @(negedge SYS_CLK);
  endtask
  task automatic ftick(input logic k, input logic [3:0] c);
    link2.cke = k;
    link2.cmd = c;
    #62.5 link2.ck = 1'b1;
    #62.5 link2.ck = 1'b0;
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #900000;
    mismatches++;
    conclude();
  end
  initial begin
    RST_N = 1'b0;
    {req_valid, req_cmd, req_ba, req_a10, req_cke, req_odt} = '0;
    {link2.ck, link2.cke, link2.ba, link2.a10, link2.odt} = '0;
    link2.cmd = CMD_DES;
    {mismatches, checked, cyc} = '0;
    {seen_ill, seen_ill2} = 2'b00;
    repeat (2) @(negedge SYS_CLK);
    RST_N = 1'b1;
    @(negedge SYS_CLK);
    chk(state, DPS_IDLE);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b1, 1'b0);
    issue(CMD_MRS, 3'h0, 1'b0, 1'b1, 1'b0);
    t0 = t_taken;
    issue(CMD_NOP, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(t_taken - t0 >= MOD_CK * 2 * CK_DIV, 1'b1);
    chk(state, DPS_PPD);
    t0 = t_taken;
    issue(4'hB, 3'h5, 1'b1, 1'b0, 1'b0);
    chk(state, DPS_PPD);
    issue(CMD_DES, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(t_taken - t0 >= (CKE_MIN_CK - 1) * 2 * CK_DIV, 1'b1);
    chk(state, DPS_IDLE);
    $display("Test precharge power-down done");
    issue(CMD_ACT, 3'h2, 1'b0, 1'b1, 1'b0);
    chk(banks_open, 8'h04);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(state, DPS_APD);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(state, DPS_ACTIVE);
    issue(CMD_RD, 3'h2, 1'b0, 1'b1, 1'b0);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(state, DPS_APD);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b1, 1'b0);
    issue(CMD_PRE, 3'h0, 1'b1, 1'b1, 1'b0);
    chk(state, DPS_BUSY);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(state, DPS_PPD);
    chk(banks_open, 8'h00);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b1, 1'b0);
    $display("Test active power-down done");
    issue(CMD_REF, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(state, DPS_SREF);
    chk(sref, 1'b1);
    issue(CMD_DES, 3'h0, 1'b0, 1'b0, 1'b1);
    chk(odt_on, 1'b0);
    issue(CMD_NOP, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(sref, 1'b0);
    t0 = t_taken;
    issue(CMD_ACT, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(t_taken - t0 >= XS_CK * 2 * CK_DIV, 1'b1);
    issue(CMD_RD, 3'h0, 1'b0, 1'b1, 1'b1);
    chk(t_taken - t0 >= XSDLL_CK * 2 * CK_DIV, 1'b1);
    issue(CMD_WR, 3'h0, 1'b0, 1'b1, 1'b0);
    chk(t_taken - t0 >= WR_AFTER_SRX_CK * 2 * CK_DIV, 1'b1);
    $display("Test self-refresh done");
    ftick(1'b1, CMD_NOP);
    link2.odt = 1'b1;
    ftick(1'b0, CMD_REF);
    repeat (2) @(negedge SYS_CLK);
    chk(state2, DPS_SREF);
    chk(odt_on2, 1'b0);
    ftick(1'b1, CMD_NOP);
    repeat (2) @(negedge SYS_CLK);
    chk(state2, DPS_IDLE);
    chk(odt_on2, 1'b1);
    chk(seen_ill2, 1'b0);
    ftick(1'b0, CMD_ACT);
    ftick(1'b0, CMD_DES);
    repeat (10) @(negedge SYS_CLK);
    chk(seen_ill2, 1'b1);
    chk(state2 == DPS_PPD, 1'b0);
    chk(state2, DPS_IDLE);
    chk(seen_ill, 1'b0);
    $display("Test broken sequence done");
    conclude();
  end
endmodule
`default_nettype wire
